// *** adcc_conversion_control.sv ***
// Converter control: registers, clock prescaler and SAR sequencer
// What this block does
// (RULE1) Interrupt enable raises a request at each conversion end; reset clears it.
// (RULE2) Reading the result or writing status/control withdraws the request.
// (RULE3) Without interrupts, done flag sets at end, clears on result read.
// (RULE4) With interrupts enabled the done flag never sets and reads zero.
// (RULE5) Software writes zero into the done flag bit position.
// (RULE6) Continuous bit repeats conversions; otherwise one; reset clears it.
// (RULE7) Channel codes 0 to 3 select port A bits 0, 1, 4, 5.
// (RULE8) All-ones channel code powers the converter off; reset sets all-ones.
// (RULE9) Codes 11101 and 11110 pick supply and ground references.
// (RULE10) Software allows one conversion after power-up before trusting data.
// (RULE11) Stop mode aborts conversion; conversions resume after stop ends (here only continuous conversions resume; a single one stays aborted).
// (RULE12) Software waits one conversion after stop before using data.
// (RULE13) Wait mode converts normally; enabled interrupt wakes the processor.
// (RULE14) Prescaler divides bus clock by 1, 2, 4, 8 or 16.
// (RULE15) One eight-bit result register loads at every conversion end.
// (RULE16) Input source holds steady for up to 17 converter clocks.
// (RULE17) Software discards data of a conversion cut by a register write.
// (RULE18) Conversion takes sixteen converter clocks, starting after the write.
// (RULE19) Continuous results overwrite the result register regardless of reads.
// (RULE20) Result bits resolve by successive approximation, MSB first.
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_conversion_control
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compare_high,
  output logic [2:0] analog_sample_input,
  output logic [7:0] sar_trial,
  output logic converter_power_on,
  output logic conv_irq,
  output logic wake_request
);
  import adcc_pkg::*;

  localparam int STEP_COUNT = `ADCC_CONV_CLOCKS;

  typedef struct packed
  {
    logic irq_enable;
    logic cont;
    logic [4:0] channel;
    logic [2:0] div_sel;
    logic wait_mode;
    logic stop_mode;
    logic done_flag;
    logic irq_pending;
    logic [7:0] result;
    logic [7:0] trial;
    logic [3:0] pos;
    logic [4:0] step;
    logic [3:0] prescale;
    adcc_state_type state;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } adcc_regs_type;

  adcc_regs_type r;
  adcc_regs_type next_r;

  // Prescaler terminal count for the selected divide ratio
  function automatic logic [3:0] adcc_div_limit(input logic [2:0] sel);
    if (sel[2])
      adcc_div_limit = 4'hF; // RULE14
    else if (sel == 3'h3)
      adcc_div_limit = 4'h7;
    else if (sel == 3'h2)
      adcc_div_limit = 4'h3;
    else if (sel == 3'h1)
      adcc_div_limit = 4'h1;
    else
      adcc_div_limit = 4'h0;
  endfunction

  // Map a channel code to the multiplexer selection
  function automatic adcc_input_type adcc_decode(input logic [4:0] ch);
    if (ch == 5'h00)
      adcc_decode = ADCC_IN_PORT_A0; // RULE7
    else if (ch == 5'h01)
      adcc_decode = ADCC_IN_PORT_A1;
    else if (ch == 5'h02)
      adcc_decode = ADCC_IN_PORT_A4;
    else if (ch == 5'h03)
      adcc_decode = ADCC_IN_PORT_A5;
    else if (ch == `ADCC_CH_SUPPLY)
      adcc_decode = ADCC_IN_SUPPLY; // RULE9
    else if (ch == `ADCC_CH_GROUND)
      adcc_decode = ADCC_IN_GROUND;
    else
      adcc_decode = ADCC_IN_NONE; // Reserved or unused: result undefined
  endfunction

  // Status/control read image; done flag reads zero with interrupts on
  function automatic logic [7:0] adcc_status(input adcc_regs_type s);
    adcc_status = {s.done_flag & ~s.irq_enable, s.irq_enable, s.cont,
      s.channel}; // RULE4
  endfunction

  logic conv_tick;
  logic powered;
  logic wr_fire;
  logic rd_fire;
  logic wr_status;
  logic rd_result;
  logic conv_end;

  // Converter clock enable and power state
  assign powered = (r.channel != `ADCC_CH_OFF) && !r.stop_mode; // RULE8 RULE11
  assign conv_tick = (r.prescale == adcc_div_limit(r.div_sel));
  assign wr_fire = r.aw_held && r.w_held && !r.bvalid;
  assign rd_fire = s_axi_arvalid && !r.rvalid;
  assign wr_status = wr_fire && (r.aw_addr == `ADCC_OFF_STATUS_CONTROL)
    && r.w_strb[0];
  assign rd_result = rd_fire && (s_axi_araddr == `ADCC_OFF_RESULT);
  // Only a powered sequencer can complete, so a stop never blocks a clear
  assign conv_end = (r.state == ADCC_RUN) && conv_tick && powered
    && (r.step == 5'(STEP_COUNT - 1));

  // Handshake outputs; each address and data channel takes one item
  assign s_axi_awready = !r.aw_held;
  assign s_axi_wready = !r.w_held;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign analog_sample_input = adcc_decode(r.channel);
  assign sar_trial = r.trial;
  assign converter_power_on = powered;
  assign conv_irq = r.irq_pending; // RULE1
  assign wake_request = r.irq_pending && r.wait_mode; // RULE13

  // Next state: bus slave, registers and sequencer
  always_comb
  begin
    next_r = r;
    if (s_axi_awvalid && !r.aw_held)
    begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_held)
    begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;
    if (r.rvalid && s_axi_rready)
      next_r.rvalid = 1'b0;

    // Prescaler runs freely while powered
    if (!powered || conv_tick)
      next_r.prescale = 4'h0;
    else
      next_r.prescale = r.prescale + 4'h1;

    // Sequencer: sixteen converter clocks, one bit per clock early on
    case (r.state)
      ADCC_IDLE:
      begin
        next_r.step = 5'h00;
      end
      ADCC_RUN:
      begin
        if (!powered)
          next_r.state = ADCC_IDLE; // RULE11
        else if (conv_tick)
        begin
          next_r.step = r.step + 5'h01; // RULE18
          if (r.step < 5'h08)
          begin
            // Keep or drop the trial bit, then try the next lower one
            if (!compare_high)
              next_r.trial[r.pos[2:0]] = 1'b0; // RULE20
            if (r.pos != 4'h0)
            begin
              next_r.pos = r.pos - 4'h1;
              next_r.trial[r.pos[2:0] - 3'h1] = 1'b1;
            end
          end
          if (conv_end)
          begin
            next_r.result = r.trial; // RULE15 RULE19
            if (r.irq_enable)
              next_r.irq_pending = 1'b1; // RULE1
            else
              next_r.done_flag = 1'b1; // RULE3 RULE4
            next_r.state = r.cont ? ADCC_RUN : ADCC_DONE; // RULE6
            next_r.step = 5'h00;
            next_r.pos = 4'h7;
            next_r.trial = 8'h80;
          end
        end
      end
      ADCC_DONE:
      begin
        next_r.step = 5'h00;
      end
      default:
      begin
        next_r.state = ADCC_IDLE;
      end
    endcase

    // Stop mode ended with a conversion armed: resume from scratch
    if (r.state == ADCC_IDLE && powered && r.cont)
    begin
      next_r.state = ADCC_RUN; // RULE11
      next_r.pos = 4'h7;
      next_r.trial = 8'h80;
    end

    // Register write, done once both channels are held
    if (wr_fire)
    begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = `ADCC_RESP_OKAY;
      if (r.aw_addr == `ADCC_OFF_STATUS_CONTROL)
      begin
        if (wr_status)
        begin
          // Done flag bit of the write data is ignored
          next_r.irq_enable = r.w_data[`ADCC_BIT_IRQ_EN];
          next_r.cont = r.w_data[`ADCC_BIT_CONT];
          next_r.channel = r.w_data[`ADCC_CH_LSB +: 5];
          // A completion in this same cycle keeps its request
          if (!conv_end)
            next_r.irq_pending = 1'b0; // RULE2
          // A write restarts conversion on the next converter tick
          next_r.state = ADCC_RUN; // RULE18
          next_r.step = 5'h00;
          next_r.pos = 4'h7;
          next_r.trial = 8'h80;
          next_r.prescale = 4'h0;
        end
      end
      else if (r.aw_addr == `ADCC_OFF_CLOCK_SELECT)
      begin
        if (r.w_strb[0])
          next_r.div_sel = r.w_data[`ADCC_DIV_LSB +: 3];
      end
      else if (r.aw_addr == `ADCC_OFF_POWER_MODE)
      begin
        if (r.w_strb[0])
        begin
          next_r.wait_mode = r.w_data[`ADCC_BIT_WAIT]; // RULE13
          next_r.stop_mode = r.w_data[`ADCC_BIT_STOP];
        end
      end
      else if (r.aw_addr != `ADCC_OFF_RESULT)
        next_r.bresp = `ADCC_RESP_SLVERR;
    end

    // Register read; reading the result clears flag and request
    if (rd_fire)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `ADCC_RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      if (s_axi_araddr == `ADCC_OFF_STATUS_CONTROL)
        next_r.rdata[7:0] = adcc_status(r);
      else if (s_axi_araddr == `ADCC_OFF_RESULT)
        next_r.rdata[7:0] = r.result;
      else if (s_axi_araddr == `ADCC_OFF_CLOCK_SELECT)
        next_r.rdata[7:0] = {r.div_sel, 5'h00};
      else if (s_axi_araddr == `ADCC_OFF_POWER_MODE)
        next_r.rdata[1:0] = {r.stop_mode, r.wait_mode};
      else
        next_r.rresp = `ADCC_RESP_SLVERR;
    end
    // Clear loses to a completion in the same cycle
    if (rd_result && !conv_end)
    begin
      next_r.done_flag = 1'b0; // RULE3
      next_r.irq_pending = 1'b0; // RULE2
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.channel <= `ADCC_CH_RESET; // RULE8
      r.state <= ADCC_IDLE;
      r.pos <= 4'h7;
      r.trial <= 8'h80;
    end
    else
      r <= next_r;
  end
endmodule // adcc_conversion_control

// *** adcc_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_OFF_STATUS_CONTROL 4'h0
`define ADCC_OFF_RESULT 4'h4
`define ADCC_OFF_CLOCK_SELECT 4'h8
`define ADCC_OFF_POWER_MODE 4'hC
`define ADCC_BIT_DONE 7
`define ADCC_BIT_IRQ_EN 6
`define ADCC_BIT_CONT 5
`define ADCC_CH_LSB 0
`define ADCC_DIV_LSB 5
`define ADCC_BIT_WAIT 0
`define ADCC_BIT_STOP 1
`define ADCC_CH_RESET 5'h1F
`define ADCC_CH_OFF 5'h1F
`define ADCC_CH_SUPPLY 5'h1D
`define ADCC_CH_GROUND 5'h1E
`define ADCC_CH_RESERVED 5'h1B
`define ADCC_CONV_CLOCKS 16
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2
`endif

// *** adcc_pkg.sv ***
// Types shared by the converter control block
package adcc_pkg;
  typedef enum logic [1:0]
  {
    ADCC_IDLE = 2'h0,
    ADCC_RUN = 2'h1,
    ADCC_DONE = 2'h3
  } adcc_state_type;
  typedef enum logic [2:0]
  {
    ADCC_IN_PORT_A0 = 3'h0,
    ADCC_IN_PORT_A1 = 3'h1,
    ADCC_IN_PORT_A4 = 3'h2,
    ADCC_IN_PORT_A5 = 3'h3,
    ADCC_IN_SUPPLY = 3'h4,
    ADCC_IN_GROUND = 3'h5,
    ADCC_IN_NONE = 3'h7
  } adcc_input_type;
endpackage

// *** adcc_conversion_control_properties.sv ***
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
module adcc_conversion_control_properties
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [2:0] analog_sample_input,
  input wire logic [7:0] sar_trial,
  input wire logic converter_power_on,
  input wire logic conv_irq,
  input wire logic wake_request
);
  logic [3:0] last_addr;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address of the read being answered; no reset, rvalid gates its use
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
    begin
      last_addr <= s_axi_araddr;
    end
  end
  property p_rst; $rose(aresetn) |-> sar_trial == 8'h80 && !conv_irq
    && !converter_power_on && analog_sample_input == 3'h7; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_clr; conv_irq && s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 4'h4 |-> ##[1:2] !conv_irq; endproperty
  a_clr: assert property (p_clr) else $error("irq kept");
  property p_excl; s_axi_rvalid && last_addr == 4'h0
    |-> !(s_axi_rdata[7] && s_axi_rdata[6]); endproperty
  a_excl: assert property (p_excl) else $error("flag with irq");
  property p_wake; wake_request |-> conv_irq; endproperty
  a_wake: assert property (p_wake) else $error("stray wake");
  property p_sel; analog_sample_input != 3'h6; endproperty
  a_sel: assert property (p_sel) else $error("bad mux code");
  property p_top; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_top: assert property (p_top) else $error("upper bits set");
  property p_ar; s_axi_arready == !s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("arready wrong");
  property p_rhold; s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read dropped");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write resp dropped");
  // Main scenarios reached
  c_irq: cover property ($rose(conv_irq));
  c_wake: cover property (wake_request);
  c_res: cover property (s_axi_rvalid && last_addr == 4'h4);
endmodule // adcc_conversion_control_properties

// *** adcc_analog_model.sv ***
// Comparator and input mux on the far side of the converter control
`timescale 1ns/1ps
module adcc_analog_model
(
  input wire logic aclk,
  input wire logic [2:0] sel,
  input wire logic [7:0] trial,
  input wire logic power_on,
  input wire logic [3:0][7:0] level,
  output logic compare_high
);
  logic [7:0] vin;
  logic flip = 1'b0;
  // Unpowered comparator wanders so a stale level is never trusted
  always_ff @(posedge aclk)
  begin
    flip <= !flip;
  end
  // Port pins, then the fixed supply and ground references
  always_comb
  begin
    vin = sel[2] ? (sel[0] ? 8'h00 : 8'hFF) : level[sel[1:0]];
    compare_high = power_on && sel != 3'h7 ? vin >= trial : flip;
  end
endmodule // adcc_analog_model

// *** adcc_conversion_control_tb.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_conversion_control_tb;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic awrdy, wrdy, bv, arr, rv, cmp, pwr, irq, wake;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic brdy = 1'b0, rrdy = 1'b0;
  logic [1:0] bresp, rresp, bq, rq;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0][7:0] level = 32'h0;
  logic [2:0] sel, dv;
  logic [7:0] trial;
  logic [4:0] c;
  logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1D, 5'h1E};
  int failures = 0, tests_run = 0, cyc = 0, seed = 97, n;
  // Responses are accepted after a random delay of zero to two cycles
  adcc_conversion_control i_adcc_conversion_control
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .compare_high(cmp), .analog_sample_input(sel),
    .sar_trial(trial), .converter_power_on(pwr), .conv_irq(irq),
    .wake_request(wake)
  );
  adcc_analog_model i_adcc_analog_model
  (
    .aclk(aclk), .sel(sel), .trial(trial), .power_on(pwr),
    .level(level), .compare_high(cmp)
  );
  initial forever #2 aclk = !aclk;
  // Hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("%0d checks, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Address and data offered together, each released once taken
  // Handshakes are judged at the falling edge, where all is settled
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    int wt;
    wt = $unsigned($random(seed)) % 3;
    tb = 1'b0;
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!tb)
    begin
      @(negedge aclk);
      ta = awv && awrdy;
      tw = wv && wrdy;
      tb = bv && brdy;
      bq = bresp;
      @(posedge aclk);
      if (ta)
        awv <= 1'b0;
      if (tw)
        wv <= 1'b0;
      if (tb)
        brdy <= 1'b0;
      else if (bv && wt == 0)
        brdy <= 1'b1;
      else if (bv)
        wt--;
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    logic ta, tr;
    int wt;
    wt = $unsigned($random(seed)) % 3;
    tr = 1'b0;
    araddr <= a;
    arv <= 1'b1;
    while (!tr)
    begin
      @(negedge aclk);
      ta = arv && arr;
      tr = rv && rrdy;
      v = rdata;
      rq = rresp;
      @(posedge aclk);
      if (ta)
        arv <= 1'b0;
      if (tr)
        rrdy <= 1'b0;
      else if (rv && wt == 0)
        rrdy <= 1'b1;
      else if (rv)
        wt--;
    end
  endtask
  // Exact SAR outcome for an ideal comparator
  function automatic logic [7:0] exp_res(input logic [4:0] k);
    exp_res = k == 5'h1D ? 8'hFF : k == 5'h1E ? 8'h00 : level[k[1:0]];
  endfunction
  function automatic int ratio(input logic [2:0] k);
    ratio = k[2] ? 16 : 1 << k[1:0];
  endfunction
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ADCC_OFF_STATUS_CONTROL, d);
    chk(d, 32'h1F);
    chk(rq, `ADCC_RESP_OKAY);
    // Unmapped offsets answer with an error and change nothing
    wr(4'h6, 32'h0);
    chk(bq, `ADCC_RESP_SLVERR);
    rd(4'h2, d);
    chk(rq, `ADCC_RESP_SLVERR);
    // First conversion after power-up is thrown away while it settles
    wr(`ADCC_OFF_STATUS_CONTROL, 32'h0);
    do rd(`ADCC_OFF_STATUS_CONTROL, d); while (d[7] !== 1'b1);
    rd(`ADCC_OFF_RESULT, d);
    // Every divide ratio and input code, alternating flag and irq mode
    for (int i = 0; i < 30; i++)
    begin
      dv = i < 24 ? 3'(i / 6) : {1'b1, 2'($random(seed))};
      c = codes[i % 6];
      level <= $random(seed);
      wr(`ADCC_OFF_CLOCK_SELECT, {24'h0, dv, 5'h0});
      rd(`ADCC_OFF_CLOCK_SELECT, d);
      chk(d[7:5], dv);
      if ((i + i / 6) % 2)
      begin
        wr(`ADCC_OFF_STATUS_CONTROL, {24'h0, 3'b010, c});
        n = 0;
        // The write returns two to four cycles after it lands
        while (irq !== 1'b1)
        begin
          @(negedge aclk);
          n++;
        end
        @(posedge aclk);
        chk(n >= 16 * ratio(dv) - 3 && n <= 16 * ratio(dv) - 1, 1);
        rd(`ADCC_OFF_STATUS_CONTROL, d);
        chk(d[7], 1'b0);
      end
      else
      begin
        wr(`ADCC_OFF_STATUS_CONTROL, {27'h0, c});
        do rd(`ADCC_OFF_STATUS_CONTROL, d); while (d[7] !== 1'b1);
      end
      rd(`ADCC_OFF_RESULT, d);
      chk(d, {24'h0, exp_res(c)});
      rd(`ADCC_OFF_STATUS_CONTROL, d);
      chk({irq, d[7]}, 2'b00);
    end
    // Continuous mode overwrites an unread result
    level <= 32'h3C;
    wr(`ADCC_OFF_CLOCK_SELECT, 32'h0);
    wr(`ADCC_OFF_STATUS_CONTROL, 32'h20);
    repeat (40) @(posedge aclk);
    level <= 32'hC3;
    repeat (40) @(posedge aclk);
    rd(`ADCC_OFF_RESULT, d);
    chk(d, 32'hC3);
    wr(`ADCC_OFF_STATUS_CONTROL, 32'h1F);
    chk(pwr, 1'b0);
    // Reserved code selects no input
    wr(`ADCC_OFF_STATUS_CONTROL, 32'h1B);
    chk(sel, 3'h7);
    // Stop in mid-conversion aborts it; a single conversion stays dead
    wr(`ADCC_OFF_CLOCK_SELECT, 32'h80);
    wr(`ADCC_OFF_STATUS_CONTROL, 32'h40);
    repeat (20) @(posedge aclk);
    wr(`ADCC_OFF_POWER_MODE, 32'h2);
    chk(pwr, 1'b0);
    repeat (300) @(posedge aclk);
    wr(`ADCC_OFF_POWER_MODE, 32'h0);
    repeat (300) @(posedge aclk);
    chk(irq, 1'b0);
    // Continuous conversion halts in stop and resumes after it
    wr(`ADCC_OFF_CLOCK_SELECT, 32'h0);
    wr(`ADCC_OFF_STATUS_CONTROL, 32'h60);
    wr(`ADCC_OFF_POWER_MODE, 32'h2);
    repeat (40) @(posedge aclk);
    chk(irq, 1'b0);
    wr(`ADCC_OFF_POWER_MODE, 32'h0);
    repeat (40) @(posedge aclk);
    chk(irq, 1'b1);
    // Wait mode keeps converting and the irq wakes the core
    wr(`ADCC_OFF_POWER_MODE, 32'h1);
    wr(`ADCC_OFF_CLOCK_SELECT, 32'h0);
    wr(`ADCC_OFF_STATUS_CONTROL, 32'h40);
    repeat (20) @(posedge aclk);
    chk({irq, wake}, 2'b11);
    rd(`ADCC_OFF_RESULT, d);
    @(posedge aclk);
    chk(wake, 1'b0);
    // Reset after a finished conversion returns the status/control bits, irq and power to their reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ADCC_OFF_STATUS_CONTROL, d);
    chk(d, 32'h1F);
    chk({irq, pwr}, 2'b00);
    results();
  end
endmodule // adcc_conversion_control_tb
bind adcc_conversion_control adcc_conversion_control_properties
  i_adcc_conversion_control_properties (.*);
